// ---- verilog/aac_pkg.sv ----
// Register map, field layout and channel codes of the auxiliary converter result and comparator block
package aac_pkg;

  // APB address and data widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = 16;

  // Register indexes; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MEASUREMENT_RESULT = 16'h402d;
  localparam logic [IDX_W-1:0] IDX_COMPARATOR_CONTROL = 16'h4030;
  localparam logic [IDX_W-1:0] IDX_COMPARATOR_ONE_SETUP = 16'h4031;
  localparam logic [IDX_W-1:0] IDX_EVENT_FLAGS = 16'h4040;

  // Number of digital comparators and their registers
  localparam int N_CMP = 4;

  // Result register layout
  localparam int CODE_W = 12;
  localparam int TAG_W = 4;
  localparam int RES_CODE_LSB = 0;
  localparam int RES_TAG_LSB = 12;

  // Comparator control register layout
  localparam int CTL_ENA_LSB = 0;
  localparam int CTL_STATE_LSB = 8;

  // Comparator setup register layout
  localparam int SEL_W = 3;
  localparam int SET_LIMIT_LSB = 0;
  localparam int SET_DIR_BIT = 12;
  localparam int SET_SEL_LSB = 13;

  // Event flag register layout (write one to clear)
  localparam int FLG_READY_BIT = 0;
  localparam int FLG_CMP_LSB = 1;

  // Reset values
  localparam logic [REG_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic [REG_W-1:0] SETUP_RESET = 16'h0000;
  localparam logic [N_CMP-1:0] CTL_RESET = 4'h0;

  // Channel tag codes shared by the result tag and comparator source
  localparam logic [TAG_W-1:0] TAG_BACKUP = 4'h0;
  localparam logic [TAG_W-1:0] TAG_PIN_ONE = 4'h1;
  localparam logic [TAG_W-1:0] TAG_PIN_TWO = 4'h2;
  localparam logic [TAG_W-1:0] TAG_PIN_THREE = 4'h3;
  localparam logic [TAG_W-1:0] TAG_DIE_TEMP = 4'h5;
  localparam logic [TAG_W-1:0] TAG_MAIN_SUPPLY = 4'h7;
  localparam logic [SEL_W-1:0] SEL_BACKUP = 3'h0;

endpackage : aac_pkg

// ---- verilog/aac_cmp_if.sv ----
// Carrier between the top block and one digital comparator
`timescale 1ns/1ps
interface aac_cmp_if;
  logic conv_valid;
  logic [aac_pkg::CODE_W-1:0] conv_code;
  logic [aac_pkg::TAG_W-1:0] conv_tag;
  logic cmp_enable;
  logic [aac_pkg::SEL_W-1:0] cmp_channel_select;
  logic cmp_direction;
  logic [aac_pkg::CODE_W-1:0] cmp_limit;
  logic cmp_state;
  logic cmp_hit;

  modport top (
    output conv_valid,
    output conv_code,
    output conv_tag,
    output cmp_enable,
    output cmp_channel_select,
    output cmp_direction,
    output cmp_limit,
    input cmp_state,
    input cmp_hit
  );

  modport cmp (
    input conv_valid,
    input conv_code,
    input conv_tag,
    input cmp_enable,
    input cmp_channel_select,
    input cmp_direction,
    input cmp_limit,
    output cmp_state,
    output cmp_hit
  );
endinterface : aac_cmp_if

// ---- verilog/aac_cmp.sv ----
// One digital threshold comparator on freshly converted results
`timescale 1ns/1ps
module aac_cmp #(
  parameter bit IS_FOURTH = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  aac_cmp_if.cmp cif
);

  logic state_r;
  logic state_nxt;
  logic hit_r;
  logic hit_nxt;
  wire logic src_legal;
  wire logic chan_match;
  wire logic at_or_above;
  wire logic detect;
  wire logic evaluate;

  // Source zero watches the backup battery, only on the fourth comparator
  assign src_legal = IS_FOURTH || (cif.cmp_channel_select != aac_pkg::SEL_BACKUP);
  assign chan_match = src_legal && (cif.conv_tag == {1'b0, cif.cmp_channel_select});
  // Limit coded exactly as the result code, unsigned compare
  assign at_or_above = (cif.conv_code >= cif.cmp_limit);
  assign detect = cif.cmp_direction ? at_or_above : ~at_or_above;
  // Evaluate only on a new conversion, only when enabled
  assign evaluate = cif.conv_valid && cif.cmp_enable && chan_match;

  // Status holds between evaluations; hit pulses on a detection
  always_comb begin
    state_nxt = evaluate ? detect : state_r;
    hit_nxt = evaluate && detect;
  end

  // Comparator flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign cif.cmp_state = state_r;
  assign cif.cmp_hit = hit_r;

endmodule : aac_cmp

// ---- verilog/aac_top.sv ----
// Auxiliary converter result register, four threshold comparators and APB register slave
//
// Overview of operation
// - Result holds tag 15:12, code 11:0
// - Tags 1-3 pins, 5 temperature, 7 supply
// - Each conversion overwrites the single result
// - Voltage code step is 1.465 millivolts
// - Temperature is 498 minus code, over 1.09
// - Ready event only once result is readable
// - Four comparators, each status and event flag
// - Enables at control bits 3 down to 0
// - Compare only right after a conversion completes
// - Source select in setup bits 15:13
// - Only comparator four watches backup battery
// - Direction bit picks above or below
// - Status bits 11 down to 8, read-only
// - Limit coded like the monitored channel code
// - Direction bit 12, limit bits 11:0
// - Source zero reserved except comparator four
// - Ready flag clears only by writing one
`timescale 1ns/1ps
module aac_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [aac_pkg::ADDR_W-1:0] paddr,
  input wire logic [aac_pkg::DATA_W-1:0] pwdata,
  output logic [aac_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_done,
  input wire logic [aac_pkg::CODE_W-1:0] conv_code,
  input wire logic [aac_pkg::TAG_W-1:0] conv_tag,
  output logic result_ready_flag,
  output logic [aac_pkg::N_CMP-1:0] cmp_event
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int N = aac_pkg::N_CMP;
  localparam int PAD_W = aac_pkg::DATA_W - aac_pkg::REG_W;

  logic [aac_pkg::REG_W-1:0] result_r;
  logic [aac_pkg::REG_W-1:0] result_nxt;
  logic [N-1:0] enable_r;
  logic [N-1:0] enable_nxt;
  logic [aac_pkg::REG_W-1:0] setup_r [N];
  logic ready_flag_r;
  logic ready_flag_nxt;
  logic [N-1:0] event_r;
  logic [N-1:0] event_nxt;
  logic pready_r;
  logic pslverr_r;
  logic [aac_pkg::DATA_W-1:0] prdata_r;
  logic [aac_pkg::REG_W-1:0] rd_mux;

  wire logic [aac_pkg::IDX_W-1:0] word_idx;
  wire logic hit_result;
  wire logic hit_control;
  wire logic hit_flags;
  wire logic [N-1:0] hit_setup;
  wire logic mapped;
  wire logic access_end;
  wire logic wr_go;
  wire logic wr_control;
  wire logic wr_flags;
  wire logic [N-1:0] state_vec;
  wire logic [N-1:0] hit_vec;
  wire logic [aac_pkg::REG_W-1:0] control_view;
  wire logic [aac_pkg::REG_W-1:0] flags_view;
  wire logic [aac_pkg::REG_W-1:0] setup_view;

  // Elaboration check: layout fixes four comparators
  if (N != 4) begin : g_bad_n
    $error("aac_top supports exactly four comparators");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB address decode

  assign word_idx = paddr[aac_pkg::ADDR_W-1:2];
  assign hit_result = (word_idx == aac_pkg::IDX_MEASUREMENT_RESULT);
  assign hit_control = (word_idx == aac_pkg::IDX_COMPARATOR_CONTROL);
  assign hit_flags = (word_idx == aac_pkg::IDX_EVENT_FLAGS);
  assign mapped = hit_result | hit_control | hit_flags | (|hit_setup);
  // Access ends at the edge that samples pready high
  assign access_end = psel & penable & pready_r;
  assign wr_go = access_end & pwrite & mapped;
  assign wr_control = wr_go & hit_control;
  assign wr_flags = wr_go & hit_flags;

  // Per-comparator setup decode and register
  for (genvar i = 0; i < N; i++) begin : g_setup
    assign hit_setup[i] = (word_idx == (aac_pkg::IDX_COMPARATOR_ONE_SETUP + aac_pkg::IDX_W'(i)));

    // Source, direction and limit, reset to zero
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        setup_r[i] <= aac_pkg::SETUP_RESET;
      end else if (wr_go && hit_setup[i]) begin
        setup_r[i] <= pwdata[aac_pkg::REG_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comparators

  for (genvar i = 0; i < N; i++) begin : g_cmp
    aac_cmp_if cif ();

    // New result goes to every comparator in the same cycle it is stored
    assign cif.conv_valid = conv_done;
    assign cif.conv_code = conv_code;
    assign cif.conv_tag = conv_tag;
    assign cif.cmp_enable = enable_r[i];
    assign cif.cmp_channel_select = setup_r[i][aac_pkg::SET_SEL_LSB +: aac_pkg::SEL_W];
    assign cif.cmp_direction = setup_r[i][aac_pkg::SET_DIR_BIT];
    assign cif.cmp_limit = setup_r[i][aac_pkg::SET_LIMIT_LSB +: aac_pkg::CODE_W];
    assign state_vec[i] = cif.cmp_state;
    assign hit_vec[i] = cif.cmp_hit;

    aac_cmp #(
      .IS_FOURTH(i == N - 1)
    ) u_cmp (
      .pclk(pclk),
      .presetn(presetn),
      .cif(cif)
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result, enables and event flags

  always_comb begin
    // Latest conversion overwrites tag and code; code passed unscaled
    result_nxt = result_r;
    if (conv_done) begin
      result_nxt[aac_pkg::RES_TAG_LSB +: aac_pkg::TAG_W] = conv_tag;
      result_nxt[aac_pkg::RES_CODE_LSB +: aac_pkg::CODE_W] = conv_code;
    end
    enable_nxt = wr_control ? pwdata[aac_pkg::CTL_ENA_LSB +: N] : enable_r;
    // Write one clears; a new event in the same cycle wins
    ready_flag_nxt = ready_flag_r;
    if (wr_flags && pwdata[aac_pkg::FLG_READY_BIT]) begin
      ready_flag_nxt = 1'b0;
    end
    if (conv_done) begin
      ready_flag_nxt = 1'b1;
    end
    event_nxt = event_r;
    if (wr_flags) begin
      event_nxt = event_r & ~pwdata[aac_pkg::FLG_CMP_LSB +: N];
    end
    event_nxt = event_nxt | hit_vec;
  end

  // Result and flag flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= aac_pkg::RESULT_RESET;
      enable_r <= aac_pkg::CTL_RESET;
      ready_flag_r <= 1'b0;
      event_r <= '0;
    end else begin
      result_r <= result_nxt;
      enable_r <= enable_nxt;
      ready_flag_r <= ready_flag_nxt;
      event_r <= event_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read views and APB answer

  // Control: status read-only, enables read back
  assign control_view = (aac_pkg::REG_W'(state_vec) << aac_pkg::CTL_STATE_LSB)
    | (aac_pkg::REG_W'(enable_r) << aac_pkg::CTL_ENA_LSB);
  assign flags_view = (aac_pkg::REG_W'(event_r) << aac_pkg::FLG_CMP_LSB)
    | (aac_pkg::REG_W'(ready_flag_r) << aac_pkg::FLG_READY_BIT);

  // Reading the result has no side effect on the ready flag
  always_comb begin
    rd_mux = '0;
    for (int k = 0; k < N; k++) begin
      if (hit_setup[k]) begin
        rd_mux = setup_r[k];
      end
    end
    if (hit_result) begin
      rd_mux = result_r;
    end
    if (hit_control) begin
      rd_mux = control_view;
    end
    if (hit_flags) begin
      rd_mux = flags_view;
    end
  end
  assign setup_view = rd_mux;

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      if (psel && penable && !pready_r && !pwrite) begin
        prdata_r <= {{PAD_W{1'b0}}, setup_view};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign result_ready_flag = ready_flag_r;
  assign cmp_event = event_r;

endmodule : aac_top

// ---- bench/aac_top_properties.sv ----
// Checker of bus timing, flag and comparator event relations at the top ports
`timescale 1ns/1ps
module aac_top_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [aac_pkg::ADDR_W-1:0] paddr,
  input wire logic [aac_pkg::DATA_W-1:0] pwdata,
  input wire logic [aac_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_done,
  input wire logic [aac_pkg::CODE_W-1:0] conv_code,
  input wire logic [aac_pkg::TAG_W-1:0] conv_tag,
  input wire logic result_ready_flag,
  input wire logic [aac_pkg::N_CMP-1:0] cmp_event
);
  // Decode of the word index and of a completing write-one-to-clear
  logic [15:0] idx;
  logic mapped;
  logic clr_ready;
  assign idx = paddr[17:2];
  assign mapped = idx == aac_pkg::IDX_MEASUREMENT_RESULT || idx == aac_pkg::IDX_EVENT_FLAGS ||
    (idx >= aac_pkg::IDX_COMPARATOR_CONTROL && idx <= 16'h4034);
  assign clr_ready = psel && penable && pready && pwrite && idx == aac_pkg::IDX_EVENT_FLAGS && pwdata[0];
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Setup then first access cycle of a transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_one_wait_state: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not on second access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match decode");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_ready_on_conv: assert property (conv_done |=> result_ready_flag)
    else $error("ready flag missing after conversion");
  a_ready_sticky: assert property (result_ready_flag && !clr_ready |=> result_ready_flag)
    else $error("ready flag cleared without write");
  a_ready_clear: assert property (clr_ready && !conv_done |=> !result_ready_flag)
    else $error("ready flag not cleared by write");
  a_event_after_conv: assert property ((cmp_event & ~$past(cmp_event)) != 4'h0 |-> $past(conv_done, 2))
    else $error("comparator event without conversion");
endmodule : aac_top_properties

bind aac_top aac_top_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_done(conv_done), .conv_code(conv_code), .conv_tag(conv_tag),
  .result_ready_flag(result_ready_flag), .cmp_event(cmp_event));

// ---- bench/aac_top_tb.sv ----
// Self-checking bench of the converter result and comparator block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module aac_top_tb;
  localparam logic [15:0] RES = aac_pkg::IDX_MEASUREMENT_RESULT;
  localparam logic [15:0] CTL = aac_pkg::IDX_COMPARATOR_CONTROL;
  localparam logic [15:0] SET = aac_pkg::IDX_COMPARATOR_ONE_SETUP;
  localparam logic [15:0] FLG = aac_pkg::IDX_EVENT_FLAGS;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_done, result_ready_flag;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] conv_code;
  logic [3:0] conv_tag, cmp_event;
  logic err;
  int bad_count, num_checks;
  aac_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv_done), .conv_code(conv_code), .conv_tag(conv_tag),
    .result_ready_flag(result_ready_flag), .cmp_event(cmp_event));
  // Clock of 25 ns period
  always #12.5 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////////////
  // One APB transfer, held until pready is seen high
  task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Read a register and compare data and error response
  task rdc(input logic [15:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 32'h0);
    `CHK({err, rd}, {17'h0, exp})
  endtask : rdc
  // One conversion pulse, then one edge for the event flags
  task conv(input logic [3:0] tag, input logic [11:0] code);
    @(posedge pclk);
    conv_done <= 1'b1; conv_tag <= tag; conv_code <= code;
    @(posedge pclk);
    conv_done <= 1'b0;
    @(posedge pclk);
  endtask : conv
  //////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rdc(RES, 16'h0000);
    rdc(CTL, 16'h0000);
    for (int n = 0; n < 4; n++) rdc(SET + 16'(n), 16'h0000);
    $display("t_reset done");
  endtask : t_reset
  task t_result;
    logic [3:0] tags [5] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7};
    for (int i = 0; i < 5; i++) begin
      conv(tags[i], 12'hfff - 12'(i));
      rdc(RES, {tags[i], 12'hfff - 12'(i)});
      conv(tags[(i + 1) % 5], 12'h5a0 + 12'(i));
      rdc(RES, {tags[(i + 1) % 5], 12'h5a0 + 12'(i)});
    end
    `CHK(result_ready_flag, 1'b1)
    apb(1'b1, FLG, 32'h1);
    // The clear lands at the edge that ends the write; look one edge later
    @(posedge pclk);
    `CHK(result_ready_flag, 1'b0)
    $display("t_result done");
  endtask : t_result
  task t_cmp;
    apb(1'b1, SET, {16'h0, 3'h5, 1'b1, 12'h100});
    apb(1'b1, SET + 16'h1, {16'h0, 3'h5, 1'b0, 12'h100});
    apb(1'b1, CTL, 32'hf);
    apb(1'b1, CTL, 32'h3);
    conv(4'h5, 12'h100);
    rdc(CTL, 16'h0103);
    `CHK(cmp_event, 4'h1)
    apb(1'b1, FLG, 32'h1f);
    conv(4'h5, 12'h0ff);
    rdc(CTL, 16'h0203);
    `CHK(cmp_event, 4'h2)
    apb(1'b1, FLG, 32'h1f);
    conv(4'h1, 12'h000);
    rdc(CTL, 16'h0203);
    `CHK(cmp_event, 4'h0)
    apb(1'b1, CTL, 32'h1);
    conv(4'h5, 12'h200);
    rdc(CTL, 16'h0301);
    `CHK(cmp_event, 4'h1)
    $display("t_cmp done");
  endtask : t_cmp
  task t_backup;
    apb(1'b1, FLG, 32'h1f);
    apb(1'b1, SET + 16'h2, {16'h0, 3'h0, 1'b1, 12'h000});
    apb(1'b1, SET + 16'h3, {16'h0, 3'h0, 1'b1, 12'h000});
    apb(1'b1, CTL, 32'hc);
    conv(4'h0, 12'h010);
    rdc(CTL, 16'h0b0c);
    `CHK(cmp_event, 4'h8)
    rdc(SET + 16'h3, 16'h1000);
    apb(1'b1, CTL, 32'h0f00);
    rdc(CTL, 16'h0b00);
    apb(1'b1, RES, 32'hffff);
    rdc(RES, 16'h0010);
    apb(1'b0, 16'h4041, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("t_backup done");
  endtask : t_backup
  //////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Reset, then the scenarios in order
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    conv_done = 0; conv_code = 0; conv_tag = 0; bad_count = 0; num_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_result();
    t_cmp();
    t_backup();
    test_done();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #500000;
    bad_count++;
    test_done();
  end
endmodule : aac_top_tb
